// ==== common/axl_consts.svh ====
// What this block and the system around it do
// R1: swap destination register with addressed memory word
// R2: old register value held in internal stage
// R3: capture, read, write run uninterrupted, errors excepted
// R4: bus lock held during read and write
// R5: memory admits no other traffic while locked
// R6: arbiter priority picks winner among exchanges
// R7: snooping caches invalidate on observed writes
// R8: read error skips write, drops lock first
//
// Purpose: constants for the locked exchange unit
// Assumes: one clock, synchronous active-high reset
// Notes: widths are fixed at 32-bit data and address
`ifndef AXL_CONSTS_SVH
`define AXL_CONSTS_SVH
`define AXL_DATA_W 32
`define AXL_ADDR_W 32
`define AXL_REG_W 5
`define AXL_ZERO_DATA 32'h0000_0000
`define AXL_ZERO_ADDR 32'h0000_0000
`define AXL_ZERO_REG 5'h00
`define AXL_FLAG_CLR 1'h0
`endif

// ==== common/axl_pkg.sv ====
// Purpose: types for the locked exchange unit
// Assumes: constants header is included once here
// Notes: state order has no meaning
`include "axl_consts.svh"
package axl_pkg;
   typedef enum logic [2:0] {
      AXL_IDLE,
      AXL_READ,
      AXL_WRITE,
      AXL_DONE,
      AXL_FAULT
   } axl_state_type;
endpackage

// ==== tb/atomic_exchange_bus_lock_test.sv ====
// Purpose: random exchanges against a shadow memory
// Assumes: one exchange in flight
// Notes: starts given while busy must be ignored
`timescale 1ns/1ns
module atomic_exchange_bus_lock_test;
   logic i_ref_clk = 0, i_sys_rst = 1, i_xchg_start = 0;
   logic [1:0] fail = 0;
   logic [31:0] i_xchg_addr = 0, i_dest_value = 0, i_mem_rdata;
   logic [31:0] o_mem_addr, o_mem_wdata, o_rf_wdata;
   logic [4:0] i_xchg_dest = 0, o_rf_addr;
   logic i_mem_ack, i_mem_err, o_busy, o_mem_req, o_mem_we, o_bus_lock_hold;
   logic o_rf_we, o_done, o_exception;
   logic [31:0] sh [logic [31:0]];
   int errors = 0, num_checks = 0, cyc = 0;
   axl_exchange dut (.*);
   axl_mem_model mem (.i_ref_clk(i_ref_clk), .i_req(o_mem_req), .i_we(o_mem_we),
      .i_fail_rd(fail[0]), .i_fail_wr(fail[1]), .i_addr(o_mem_addr),
      .i_wdata(o_mem_wdata), .o_ack(i_mem_ack),
      .o_err(i_mem_err), .o_rdata(i_mem_rdata));
   initial forever #4 i_ref_clk = ~i_ref_clk;
   always @(posedge i_ref_clk) if (++cyc > 6000) begin errors++; print_verdict; end
   task automatic chk(input logic ok, input string s);
      num_checks++;
      if (!ok) begin errors++; $display("mismatch %0t %s", $time, s); end
   endtask
   task automatic xchg(input logic [31:0] a, v, input logic [4:0] d, input logic [1:0] f);
      logic [31:0] old;
      int n;
      old = sh.exists(a) ? sh[a] : ~a;
      @(negedge i_ref_clk);
      {i_xchg_start, i_xchg_addr, i_dest_value, i_xchg_dest, fail} = {1'b1, a, v, d, f};
      @(negedge i_ref_clk);
      for (n = 0; n < 40 && o_done !== 1 && o_exception !== 1; n++) begin
         i_xchg_start = n[0];
         i_xchg_addr = a ^ {32{n[0]}};
         @(negedge i_ref_clk);
      end
      i_xchg_start = 0;
      chk(f ? o_exception === 1 && o_rf_we === 0 : o_done === 1 && o_rf_we === 1, "end");
      chk(f != 0 || o_exception === 0, "spurious exception");
      chk(o_bus_lock_hold === 0, "lock held after end");
      chk(f || (o_rf_addr === d && o_rf_wdata === old), "register value");
      if (!f) sh[a] = v;
      chk(mem.m.exists(a) ? mem.m[a] === sh[a] : f != 0, "memory word");
      @(negedge i_ref_clk);
      chk(o_busy === 0, "busy after end");
      $display("exchange at %h ended", a);
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      void'($urandom(32'h815d));
      repeat (3) @(negedge i_ref_clk);
      i_sys_rst = 0;
      xchg(0, 32'h1234_5678, 5'h1f, 2'h0);
      xchg(0, 32'h0000_0001, 5'h00, 2'h1);
      xchg(0, 32'h0000_00ff, 5'h03, 2'h2);
      repeat (60) xchg($urandom % 4, $urandom, 5'($urandom),
         $urandom % 5 == 0 ? 2'(1 + $urandom % 2) : 2'h0);
      print_verdict;
   end
endmodule

// ==== tb/axl_exchange_chk_sva.sv ====
// Purpose: port checks on the exchange unit
// Assumes: an error beats an ack in the same cycle
// Notes: bound to every exchange unit instance
`timescale 1ns/1ns
module axl_exchange_chk (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_xchg_start,
   input wire logic i_mem_ack,
   input wire logic i_mem_err,
   input wire logic o_busy,
   input wire logic o_mem_req,
   input wire logic o_mem_we,
   input wire logic o_bus_lock_hold,
   input wire logic o_rf_we,
   input wire logic o_done,
   input wire logic o_exception
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);
   a_start_opens_read: assert property (
      i_xchg_start && !o_busy |=> o_mem_req && !o_mem_we && o_bus_lock_hold)
      else $error("read not opened");
   a_lock_unbroken: assert property (
      o_mem_req && o_mem_we |-> $past(o_mem_req) && $past(o_bus_lock_hold))
      else $error("lock dropped before write");
   a_write_follows: assert property (
      o_mem_req && !o_mem_we && i_mem_ack && !i_mem_err |=> o_mem_req && o_mem_we)
      else $error("write missing");
   a_done_after_write: assert property (
      o_mem_req && o_mem_we && i_mem_ack && !i_mem_err
      |=> o_done && o_rf_we && !o_bus_lock_hold && !o_exception)
      else $error("done missing");
   a_err_no_write: assert property (
      o_mem_req && !o_mem_we && i_mem_err
      |=> !o_mem_req && !o_bus_lock_hold ##1 o_exception && !o_rf_we)
      else $error("write after read error");
   a_werr_no_reg: assert property (
      o_mem_req && o_mem_we && i_mem_err
      |=> !o_mem_req && !o_bus_lock_hold ##1 o_exception && !o_rf_we && !o_done)
      else $error("register written after write error");
   c_done: cover property (o_done);
   c_fault: cover property (o_exception);
   c_refused: cover property (i_xchg_start && o_busy);
   c_write_fault: cover property (o_mem_req && o_mem_we && i_mem_err);
endmodule
bind axl_exchange axl_exchange_chk chk (.*);

// ==== tb/axl_mem_model.sv ====
// Purpose: memory and arbiter stand-in
// Assumes: sole requester, always granted
// Notes: idle read data toggles so stale data never looks valid
`timescale 1ns/1ns
module axl_mem_model (
   input wire logic i_ref_clk,
   input wire logic i_req,
   input wire logic i_we,
   input wire logic i_fail_rd,
   input wire logic i_fail_wr,
   input wire logic [31:0] i_addr,
   input wire logic [31:0] i_wdata,
   output logic o_ack = 0,
   output logic o_err = 0,
   output logic [31:0] o_rdata = 0
);
   logic [31:0] m [logic [31:0]];
   int w = 0;
   always @(negedge i_ref_clk) begin
      {o_ack, o_err} = 2'b00;
      o_rdata = ~o_rdata;
      if (i_req && w > 0) w--;
      else if (i_req) begin
         w = $urandom % 3; // no other traffic enters while locked
         o_err = i_we ? i_fail_wr : i_fail_rd;
         o_ack = !o_err;
         if (i_we && o_ack) m[i_addr] = i_wdata; // no cache copies to invalidate
         if (!i_we) o_rdata = m.exists(i_addr) ? m[i_addr] : ~i_addr;
      end
   end
endmodule

// ==== verilog/axl_exchange.sv ====
// Purpose: locked read-then-write exchange of a register and a memory word
// Assumes: memory answers each request with one i_mem_ack or i_mem_err pulse
// Notes: memory holds other masters off while o_bus_lock_hold is high
`timescale 1ns/1ns
`include "axl_consts.svh"
module axl_exchange
   import axl_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_xchg_start,
   input wire logic [`AXL_ADDR_W-1:0] i_xchg_addr,
   input wire logic [`AXL_REG_W-1:0] i_xchg_dest,
   input wire logic [`AXL_DATA_W-1:0] i_dest_value,
   input wire logic i_mem_ack,
   input wire logic i_mem_err,
   input wire logic [`AXL_DATA_W-1:0] i_mem_rdata,
   output logic o_busy,
   output logic o_mem_req,
   output logic o_mem_we,
   output logic [`AXL_ADDR_W-1:0] o_mem_addr,
   output logic [`AXL_DATA_W-1:0] o_mem_wdata,
   output logic o_bus_lock_hold,
   output logic o_rf_we,
   output logic [`AXL_REG_W-1:0] o_rf_addr,
   output logic [`AXL_DATA_W-1:0] o_rf_wdata,
   output logic o_done,
   output logic o_exception
);
   // sequencer state and the access strobes it launches
   axl_state_type state_reg, state_next;
   logic busy_reg, busy_next;
   logic req_reg, req_next;
   logic we_reg, we_next;
   logic lock_reg, lock_next;

   // operands caught at the start, and the word fetched by the read
   logic [`AXL_DATA_W-1:0] temp_reg, temp_next;
   logic [`AXL_DATA_W-1:0] rdata_reg, rdata_next;
   logic [`AXL_ADDR_W-1:0] addr_reg, addr_next;
   logic [`AXL_REG_W-1:0] dest_reg, dest_next;

   // one-cycle results towards the register file and the sequencer
   logic rf_we_reg, rf_we_next;
   logic done_reg, done_next;
   logic exc_reg, exc_next;

   // a start counts only from idle; one raised mid-sequence is dropped
   // without trace, so the issuing side must wait for busy to fall
   function automatic logic axl_take_start(
      input axl_state_type state,
      input logic start
   );
      return (state == AXL_IDLE) && start;
   endfunction

   // an error outranks an ack in the same cycle, so a faulty access can
   // never be taken as finished
   function automatic logic axl_answer_ok(
      input logic ack,
      input logic err
   );
      return ack && !err;
   endfunction

   // sequencer: the lock must cover the read and the write without a gap,
   // because the arbiter reopens the bus the moment it sees the lock fall;
   // a single registered lock flag keeps that edge clean
   always_comb begin
      state_next = state_reg;
      req_next = 1'h0;
      we_next = 1'h0;
      lock_next = lock_reg;
      case (state_reg)
         AXL_IDLE: begin
            if (axl_take_start(state_reg, i_xchg_start)) begin
               req_next = 1'h1;
               lock_next = 1'h1; // [R4]
               state_next = AXL_READ;
            end
         end

         AXL_READ: begin
            // new starts are ignored until the sequence ends [R3]
            if (i_mem_err) begin
               // drop the lock now; exception follows a cycle later [R8]
               lock_next = 1'h0;
               state_next = AXL_FAULT;
            end else if (axl_answer_ok(i_mem_ack, i_mem_err)) begin
               // the write goes out at once, still under the lock [R1] [R4]
               req_next = 1'h1;
               we_next = 1'h1;
               state_next = AXL_WRITE;
            end else begin
               req_next = 1'h1;
            end
         end

         AXL_WRITE: begin
            if (i_mem_err) begin
               // a failed write still frees the bus before the exception
               lock_next = 1'h0;
               state_next = AXL_FAULT; // [R3]
            end else if (axl_answer_ok(i_mem_ack, i_mem_err)) begin
               // lock falls with the write answer, not a cycle later [R4]
               lock_next = 1'h0;
               state_next = AXL_DONE;
            end else begin
               req_next = 1'h1;
               we_next = 1'h1;
            end
         end

         AXL_DONE: begin
            // one settling cycle before the next start is taken
            state_next = AXL_IDLE;
         end

         AXL_FAULT: begin
            state_next = AXL_DONE;
         end

         default: begin
            state_next = AXL_IDLE;
         end
      endcase
      busy_next = (state_next != AXL_IDLE);
      // synchronous clear outranks everything above
      if (i_sys_rst) begin
         state_next = AXL_IDLE;
         busy_next = `AXL_FLAG_CLR;
         req_next = `AXL_FLAG_CLR;
         we_next = `AXL_FLAG_CLR;
         lock_next = `AXL_FLAG_CLR;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      state_reg <= state_next;
      busy_reg <= busy_next;
      req_reg <= req_next;
      we_reg <= we_next;
      lock_reg <= lock_next;
   end

   // operand capture; the old register value is parked in this stage so
   // the register file sees a single write, at the very end
   always_comb begin
      temp_next = temp_reg;
      rdata_next = rdata_reg;
      addr_next = addr_reg;
      dest_next = dest_reg;
      if (axl_take_start(state_reg, i_xchg_start)) begin
         // no other register is touched by the exchange [R2]
         temp_next = i_dest_value;
         addr_next = i_xchg_addr;
         dest_next = i_xchg_dest;
      end
      if ((state_reg == AXL_READ) && axl_answer_ok(i_mem_ack, i_mem_err)) begin
         rdata_next = i_mem_rdata; // [R1]
      end
      if (i_sys_rst) begin
         temp_next = `AXL_ZERO_DATA;
         rdata_next = `AXL_ZERO_DATA;
         addr_next = `AXL_ZERO_ADDR;
         dest_next = `AXL_ZERO_REG;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      temp_reg <= temp_next;
      rdata_reg <= rdata_next;
      addr_reg <= addr_next;
      dest_reg <= dest_next;
   end

   // results; the exception trails the lock release by a cycle so the
   // bus is already free when the handler starts
   always_comb begin
      rf_we_next = 1'h0;
      done_next = 1'h0;
      exc_next = 1'h0;
      if ((state_reg == AXL_WRITE) && axl_answer_ok(i_mem_ack, i_mem_err)) begin
         // register takes the fetched word only once the write is safe [R1]
         rf_we_next = 1'h1;
         done_next = 1'h1;
      end
      if (state_reg == AXL_FAULT) begin
         exc_next = 1'h1; // [R8]
      end
      if (i_sys_rst) begin
         rf_we_next = `AXL_FLAG_CLR;
         done_next = `AXL_FLAG_CLR;
         exc_next = `AXL_FLAG_CLR;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      rf_we_reg <= rf_we_next;
      done_reg <= done_next;
      exc_reg <= exc_next;
   end

   // every output is a plain copy of a flop, so no decode glitch leaves
   always_comb begin
      o_busy = busy_reg;
      o_mem_req = req_reg;
      o_mem_we = we_reg;
      o_mem_addr = addr_reg;
      o_mem_wdata = temp_reg; // [R1]
      o_bus_lock_hold = lock_reg; // [R4]
      o_rf_we = rf_we_reg;
      o_rf_addr = dest_reg;
      o_rf_wdata = rdata_reg;
      o_done = done_reg;
      o_exception = exc_reg;
   end
endmodule
